// File: hdl/dama_defines.svh
// Register offsets, field positions, stored bit masks and reset values of the dual alarm match unit.
`ifndef DAMA_DEFINES_SVH
`define DAMA_DEFINES_SVH

// Register offsets on the host register port.
`define DAMA_OFS_A1_SEC      8'h08
`define DAMA_OFS_A1_MIN      8'h09
`define DAMA_OFS_A1_HR_LOW   8'h0a
`define DAMA_OFS_A1_HR_MID   8'h0b
`define DAMA_OFS_A1_HR_HIGH  8'h0c
`define DAMA_OFS_A2_MIN      8'h0d
`define DAMA_OFS_A2_HR_LOW   8'h0e
`define DAMA_OFS_A2_HR_HIGH  8'h0f
`define DAMA_OFS_FIELD_EN    8'h10
`define DAMA_OFS_IRQ_A_EN    8'h29
`define DAMA_OFS_IRQ_B_EN    8'h2a

// Storage indices inside the register file.
`define DAMA_IDX_A1_SEC      4'h0
`define DAMA_IDX_A1_MIN      4'h1
`define DAMA_IDX_A1_HR_LOW   4'h2
`define DAMA_IDX_A1_HR_MID   4'h3
`define DAMA_IDX_A1_HR_HIGH  4'h4
`define DAMA_IDX_A2_MIN      4'h5
`define DAMA_IDX_A2_HR_LOW   4'h6
`define DAMA_IDX_A2_HR_HIGH  4'h7
`define DAMA_IDX_FIELD_EN    4'h8
`define DAMA_IDX_IRQ_A_EN    4'h9
`define DAMA_IDX_IRQ_B_EN    4'ha
`define DAMA_NUM_REGS        11

// Field enable bit positions; bits 0 to 4 belong to alarm1, bits 5 to 7 to alarm2.
`define DAMA_A1_EN_LSB       0
`define DAMA_A1_EN_MSB       4
`define DAMA_A2_EN_LSB       5
`define DAMA_A2_EN_MSB       7

// Interrupt enable register bit positions.
`define DAMA_IE_ALARM1_BIT   0
`define DAMA_IE_ALARM2_BIT   1
`define DAMA_IE_PULSE_BIT    7

// Stored bit masks; bit positions that are not implemented are not kept.
`define DAMA_MASK_MIN_SEC    8'h7f
`define DAMA_MASK_HOUR       8'h3f
`define DAMA_MASK_DAY        8'h3f
`define DAMA_MASK_MONTH      8'h1f
`define DAMA_MASK_WDAY       8'h07
`define DAMA_MASK_BCD_PAIR   8'hff

// Reset values.
`define DAMA_REG_RESET       8'h00
`define DAMA_FIELD_EN_RESET  8'h00

`endif

// File: hdl/dama_pkg.sv
// Types shared by the dual alarm match unit.
package dama_pkg;
	typedef logic [7:0] dama_byte_t;
	typedef logic [3:0] dama_idx_t;
	// Register layout selection for the alarm bytes and field enables.
	typedef enum logic {DAMA_CALENDAR, DAMA_ELAPSED} dama_mode_t;
	// Signalling style of one interrupt output.
	typedef enum logic {DAMA_LEVEL, DAMA_PULSE} dama_irq_style_t;
endpackage

// File: hdl/dama_regfile.sv
// Small register file holding the alarm, field enable and interrupt enable bytes.
`timescale 1ns/1ps
module dama_regfile #(
	parameter int DEPTH = 11,
	parameter int WIDTH = 8
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     wr_en,
	input  wire dama_pkg::dama_idx_t      wr_idx,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic                     rd_en,
	input  wire logic                     rd_zero,
	input  wire dama_pkg::dama_idx_t      rd_idx,
	output logic      [WIDTH-1:0]         rd_data,
	output logic      [DEPTH*WIDTH-1:0]   all_q
);
	import dama_pkg::*;

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [WIDTH-1:0] rd_data_ff;
	logic [WIDTH-1:0] nxt_rd_data;

	// Write port and registered read port; an unmapped read returns zero.
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			nxt_mem[i] = mem_ff[i];
		end
		if (wr_en && (int'(wr_idx) < DEPTH)) begin
			nxt_mem[wr_idx] = wr_data;
		end
		nxt_rd_data = rd_data_ff;
		if (rd_en) begin
			nxt_rd_data = (rd_zero || (int'(rd_idx) >= DEPTH)) ? '0 : mem_ff[rd_idx];
		end
	end

	// Storage registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
			rd_data_ff <= '0;
		end else begin
			mem_ff     <= nxt_mem;
			rd_data_ff <= nxt_rd_data;
		end
	end

	// Flat view of every byte for the comparators.
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			all_q[i*WIDTH +: WIDTH] = mem_ff[i];
		end
	end

	assign rd_data = rd_data_ff;
endmodule // dama_regfile

// File: hdl/dama_top.sv
// Dual alarm comparators with sticky flags and two active-low interrupt outputs.
// Behaviour
// RULE1 - Calendar alarm1: second to month, enables bits 0-4.
// RULE2 - Calendar alarm2: minute, hour, weekday, enables bits 5-7.
// RULE3 - Field enable byte at 10h resets to zero.
// RULE4 - Disabled fields never take part in matching.
// RULE5 - Increment into full match sets alarm flag.
// RULE6 - Flags clear only on host command.
// RULE7 - Cleared flag resets only on fresh match.
// RULE8 - Elapsed ranges: alarm1 999999 h, alarm2 9999 h.
// RULE9 - Elapsed alarm1: seconds, minutes, three hour bytes.
// RULE10 - Elapsed alarm1 enables: sec, min, low/mid/top hours.
// RULE11 - Elapsed alarm2: minutes, lower and upper hours.
// RULE12 - Packed BCD bytes; unimplemented bits not stored.
// RULE13 - Four interrupt enables at 29h and 2Ah.
// RULE14 - Pulse style: one pulse per matching increment.
// RULE15 - Level style: output follows enabled flags.
// RULE16 - Pulse repeats on new match without clearing.
// RULE17 - Mode bit selects elapsed or calendar layout.
// RULE18 - Weekday 0-6; hour byte keeps AM/PM layout.
// RULE19 - Alarm without enabled fields never matches.
// RULE20 - Match evaluated once per increment, post-increment.
`timescale 1ns/1ps
`include "dama_defines.svh"
module dama_top #(
	parameter int NUM_REGS = `DAMA_NUM_REGS
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire dama_pkg::dama_byte_t reg_addr,
	input  wire dama_pkg::dama_byte_t reg_wdata,
	output dama_pkg::dama_byte_t     reg_rdata,
	input  wire logic                flag_clr_first,
	input  wire logic                flag_clr_second,
	input  wire logic                elapsed_time_mode_sel,
	input  wire logic                time_tick,
	input  wire dama_pkg::dama_byte_t cur_sec,
	input  wire dama_pkg::dama_byte_t cur_min,
	input  wire dama_pkg::dama_byte_t cur_hr_low,
	input  wire dama_pkg::dama_byte_t cur_hr_mid,
	input  wire dama_pkg::dama_byte_t cur_hr_high,
	input  wire dama_pkg::dama_byte_t cur_day,
	input  wire dama_pkg::dama_byte_t cur_month,
	input  wire dama_pkg::dama_byte_t cur_wday,
	output logic                     first_alarm_flag,
	output logic                     second_alarm_flag,
	output logic                     irq_out_a_n,
	output logic                     irq_out_b_n
);
	import dama_pkg::*;

	// Maps a port offset to a storage index; the top bit says the offset is mapped.
	function automatic logic [4:0] reg_index(input dama_byte_t a);
		logic [4:0] r;
		r = 5'h00;
		if ((a >= `DAMA_OFS_A1_SEC) && (a <= `DAMA_OFS_FIELD_EN)) begin
			r = {1'b1, 4'(a - `DAMA_OFS_A1_SEC)};
		end else if (a == `DAMA_OFS_IRQ_A_EN) begin
			r = {1'b1, `DAMA_IDX_IRQ_A_EN};
		end else if (a == `DAMA_OFS_IRQ_B_EN) begin
			r = {1'b1, `DAMA_IDX_IRQ_B_EN};
		end
		return r;
	endfunction

	// Bits kept for one alarm byte under the layout in force at the write.
	function automatic dama_byte_t store_mask(input dama_idx_t idx, input dama_mode_t m);
		dama_byte_t k;
		k = `DAMA_MASK_BCD_PAIR;
		case (idx)
			`DAMA_IDX_A1_SEC, `DAMA_IDX_A1_MIN, `DAMA_IDX_A2_MIN: k = `DAMA_MASK_MIN_SEC;
			`DAMA_IDX_A1_HR_LOW, `DAMA_IDX_A2_HR_LOW: k = (m == DAMA_ELAPSED) ? `DAMA_MASK_BCD_PAIR : `DAMA_MASK_HOUR;
			`DAMA_IDX_A1_HR_MID: k = (m == DAMA_ELAPSED) ? `DAMA_MASK_BCD_PAIR : `DAMA_MASK_DAY;
			`DAMA_IDX_A1_HR_HIGH: k = (m == DAMA_ELAPSED) ? `DAMA_MASK_BCD_PAIR : `DAMA_MASK_MONTH;
			`DAMA_IDX_A2_HR_HIGH: k = (m == DAMA_ELAPSED) ? `DAMA_MASK_BCD_PAIR : `DAMA_MASK_WDAY;
			default: k = `DAMA_MASK_BCD_PAIR;
		endcase
		return k;
	endfunction

	// Field compare over the bits that the current layout implements.
	function automatic logic field_eq(input dama_byte_t alm, input dama_byte_t cur, input dama_byte_t k);
		return (alm & k) == (cur & k);
	endfunction

	// Alarm matches when it has an enabled field and every enabled field agrees.
	function automatic logic alarm_hit(input logic [4:0] en, input logic [4:0] eq);
		return (|en) && (&(eq | ~en));
	endfunction

	dama_mode_t                  mode;
	logic [4:0]                  wr_map;
	logic [4:0]                  rd_map;
	dama_byte_t                  wr_masked;
	logic [NUM_REGS*8-1:0]       regs_q;
	dama_byte_t                  alm [NUM_REGS];
	dama_byte_t                  field_en;
	dama_byte_t                  ie_a;
	dama_byte_t                  ie_b;
	dama_irq_style_t             style_a;
	dama_irq_style_t             style_b;
	logic [4:0]                  a1_eq;
	logic [2:0]                  a2_eq;
	logic [4:0]                  a1_en;
	logic [2:0]                  a2_en;
	logic                        match1;
	logic                        match2;
	logic                        ev1;
	logic                        ev2;
	logic                        flag1_ff;
	logic                        flag2_ff;
	logic                        nxt_flag1;
	logic                        nxt_flag2;
	logic                        irq_a_n_ff;
	logic                        irq_b_n_ff;
	logic                        nxt_irq_a_n;
	logic                        nxt_irq_b_n;

	// Layout of alarm bytes and enable bits follows the mode bit.
	assign mode = elapsed_time_mode_sel ? DAMA_ELAPSED : DAMA_CALENDAR; // RULE17

	// Port decode and storage masking before a byte reaches the file.
	assign wr_map    = reg_index(reg_addr);
	assign rd_map    = reg_index(reg_addr);
	assign wr_masked = reg_wdata & store_mask(wr_map[3:0], mode); // RULE12 RULE18

	dama_regfile #(
		.DEPTH (NUM_REGS),
		.WIDTH (8)
	) u_regs (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (reg_wr && wr_map[4]),
		.wr_idx  (wr_map[3:0]),
		.wr_data (wr_masked),
		.rd_en   (reg_rd),
		.rd_zero (!rd_map[4]),
		.rd_idx  (rd_map[3:0]),
		.rd_data (reg_rdata),
		.all_q   (regs_q)
	);

	// Unpack the stored bytes.
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			alm[i] = regs_q[i*8 +: 8];
		end
	end

	assign field_en = alm[`DAMA_IDX_FIELD_EN]; // RULE3
	assign ie_a     = alm[`DAMA_IDX_IRQ_A_EN]; // RULE13
	assign ie_b     = alm[`DAMA_IDX_IRQ_B_EN]; // RULE13
	assign style_a  = ie_a[`DAMA_IE_PULSE_BIT] ? DAMA_PULSE : DAMA_LEVEL;
	assign style_b  = ie_b[`DAMA_IE_PULSE_BIT] ? DAMA_PULSE : DAMA_LEVEL;
	assign a1_en    = field_en[`DAMA_A1_EN_MSB:`DAMA_A1_EN_LSB]; // RULE1 RULE10
	assign a2_en    = field_en[`DAMA_A2_EN_MSB:`DAMA_A2_EN_LSB]; // RULE2 RULE11

	// Per-field comparisons; the same byte slots serve both layouts.
	always_comb begin
		a1_eq[0] = field_eq(alm[`DAMA_IDX_A1_SEC], cur_sec, `DAMA_MASK_MIN_SEC); // RULE1 RULE9
		a1_eq[1] = field_eq(alm[`DAMA_IDX_A1_MIN], cur_min, `DAMA_MASK_MIN_SEC);
		a2_eq[0] = field_eq(alm[`DAMA_IDX_A2_MIN], cur_min, `DAMA_MASK_MIN_SEC); // RULE2 RULE11
		if (mode == DAMA_ELAPSED) begin
			// Hour bytes span up to 999999 h for alarm1 and 9999 h for alarm2.
			a1_eq[2] = field_eq(alm[`DAMA_IDX_A1_HR_LOW], cur_hr_low, `DAMA_MASK_BCD_PAIR); // RULE8 RULE9
			a1_eq[3] = field_eq(alm[`DAMA_IDX_A1_HR_MID], cur_hr_mid, `DAMA_MASK_BCD_PAIR);
			a1_eq[4] = field_eq(alm[`DAMA_IDX_A1_HR_HIGH], cur_hr_high, `DAMA_MASK_BCD_PAIR);
			a2_eq[1] = field_eq(alm[`DAMA_IDX_A2_HR_LOW], cur_hr_low, `DAMA_MASK_BCD_PAIR); // RULE8 RULE11
			a2_eq[2] = field_eq(alm[`DAMA_IDX_A2_HR_HIGH], cur_hr_mid, `DAMA_MASK_BCD_PAIR);
		end else begin
			a1_eq[2] = field_eq(alm[`DAMA_IDX_A1_HR_LOW], cur_hr_low, `DAMA_MASK_HOUR); // RULE18
			a1_eq[3] = field_eq(alm[`DAMA_IDX_A1_HR_MID], cur_day, `DAMA_MASK_DAY);
			a1_eq[4] = field_eq(alm[`DAMA_IDX_A1_HR_HIGH], cur_month, `DAMA_MASK_MONTH);
			a2_eq[1] = field_eq(alm[`DAMA_IDX_A2_HR_LOW], cur_hr_low, `DAMA_MASK_HOUR);
			a2_eq[2] = field_eq(alm[`DAMA_IDX_A2_HR_HIGH], cur_wday, `DAMA_MASK_WDAY); // RULE18
		end
	end

	// Disabled fields are forced true; an alarm with no field enabled never hits.
	assign match1 = alarm_hit(a1_en, a1_eq); // RULE4 RULE19
	assign match2 = alarm_hit({2'b00, a2_en}, {2'b11, a2_eq}); // RULE4 RULE19

	// A match counts only on the increment cycle, with the counter already advanced.
	assign ev1 = time_tick && match1; // RULE20
	assign ev2 = time_tick && match2; // RULE20

	// Sticky flags; a new match wins over a clear command in the same cycle.
	always_comb begin
		nxt_flag1 = ev1 || (flag1_ff && !flag_clr_first); // RULE5 RULE6 RULE7
		nxt_flag2 = ev2 || (flag2_ff && !flag_clr_second); // RULE5 RULE6 RULE7
	end

	// Interrupt outputs: pulse per matching increment or level following flags.
	always_comb begin
		logic act_a;
		logic act_b;
		act_a = 1'b0;
		act_b = 1'b0;
		case (style_a)
			DAMA_PULSE: act_a = (ie_a[`DAMA_IE_ALARM1_BIT] && ev1) || (ie_a[`DAMA_IE_ALARM2_BIT] && ev2); // RULE14 RULE16
			DAMA_LEVEL: act_a = (ie_a[`DAMA_IE_ALARM1_BIT] && nxt_flag1) || (ie_a[`DAMA_IE_ALARM2_BIT] && nxt_flag2); // RULE15
			default: act_a = 1'b0;
		endcase
		case (style_b)
			DAMA_PULSE: act_b = (ie_b[`DAMA_IE_ALARM1_BIT] && ev1) || (ie_b[`DAMA_IE_ALARM2_BIT] && ev2); // RULE14 RULE16
			DAMA_LEVEL: act_b = (ie_b[`DAMA_IE_ALARM1_BIT] && nxt_flag1) || (ie_b[`DAMA_IE_ALARM2_BIT] && nxt_flag2); // RULE15
			default: act_b = 1'b0;
		endcase
		nxt_irq_a_n = !act_a;
		nxt_irq_b_n = !act_b;
	end

	// Flag and interrupt registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag1_ff   <= 1'b0;
			flag2_ff   <= 1'b0;
			irq_a_n_ff <= 1'b1;
			irq_b_n_ff <= 1'b1;
		end else begin
			flag1_ff   <= nxt_flag1;
			flag2_ff   <= nxt_flag2;
			irq_a_n_ff <= nxt_irq_a_n;
			irq_b_n_ff <= nxt_irq_b_n;
		end
	end

	assign first_alarm_flag  = flag1_ff;
	assign second_alarm_flag = flag2_ff;
	assign irq_out_a_n       = irq_a_n_ff;
	assign irq_out_b_n       = irq_b_n_ff;

	// Checks on the alarm behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence pulse_cfg_a_s;
		style_a == DAMA_PULSE && ie_a[`DAMA_IE_ALARM1_BIT];
	endsequence

	sequence hit1_s;
		time_tick && match1;
	endsequence

	sequence low_then_release_a_s;
		!irq_out_a_n ##1 (irq_out_a_n || $past(ev1 || ev2));
	endsequence

	flag_set_a: assert property (hit1_s |=> first_alarm_flag) // RULE5
		else $error("alarm1 flag not set after matching increment");

	flag_hold_a: assert property (second_alarm_flag && !flag_clr_second |=> second_alarm_flag) // RULE6
		else $error("alarm2 flag cleared without command");

	no_rearm_a: assert property (!first_alarm_flag && !time_tick |=> !first_alarm_flag) // RULE7
		else $error("alarm1 flag set without an increment");

	empty_alarm_a: assert property (a1_en == 5'h00 && !first_alarm_flag |=> !first_alarm_flag) // RULE19
		else $error("alarm1 matched with no field enabled");

	enable_write_a: assert property (reg_wr && reg_addr == `DAMA_OFS_FIELD_EN |=> field_en == $past(reg_wdata)) // RULE3
		else $error("field enable byte not written");

	pulse_once_a: assert property (pulse_cfg_a_s and hit1_s |=> low_then_release_a_s) // RULE14
		else $error("output A pulse missing or stretched");

	pulse_repeat_a: assert property (pulse_cfg_a_s and hit1_s and first_alarm_flag |=> !irq_out_a_n) // RULE16
		else $error("no repeated pulse while flag still set");

	level_follow_a: assert property (style_b == DAMA_LEVEL && ie_b[`DAMA_IE_ALARM2_BIT] && !ev2 && second_alarm_flag
		&& !flag_clr_second |=> !irq_out_b_n) // RULE15
		else $error("output B level released while flag set");

	// Increment that matches the only enabled field of alarm1 while its flag is clear.
	sequence sec_only_hit_s;
		a1_en == 5'h01 && time_tick && a1_eq[0] && !first_alarm_flag;
	endsequence

	disabled_field_a: assert property (sec_only_hit_s |=> first_alarm_flag) // RULE4
		else $error("disabled fields blocked alarm1");

	// Writes whose stored value depends on the layout in force.
	sequence hr_high_write_s;
		reg_wr && reg_addr == `DAMA_OFS_A1_HR_HIGH && elapsed_time_mode_sel;
	endsequence

	sequence wday_write_s;
		reg_wr && reg_addr == `DAMA_OFS_A2_HR_HIGH && !elapsed_time_mode_sel;
	endsequence

	// Output B with neither alarm routed to it.
	sequence b_gated_off_s;
		!ie_b[`DAMA_IE_ALARM1_BIT] && !ie_b[`DAMA_IE_ALARM2_BIT];
	endsequence

	// Checks on the second alarm, the clear command, storage and the output gating.
	flag_set_b_a: assert property (time_tick && match2 |=> second_alarm_flag) // RULE5
		else $error("alarm2 flag not set after matching increment");

	clear_flag_a: assert property (first_alarm_flag && flag_clr_first && !ev1 |=> !first_alarm_flag) // RULE6
		else $error("alarm1 flag not cleared by command");

	no_rearm_b_a: assert property (!second_alarm_flag && !time_tick |=> !second_alarm_flag) // RULE7
		else $error("alarm2 flag set without an increment");

	empty_alarm_b_a: assert property (a2_en == 3'h0 && !second_alarm_flag |=> !second_alarm_flag) // RULE19
		else $error("alarm2 flag set with no field enabled");

	level_release_a: assert property (style_a == DAMA_LEVEL && !nxt_flag1 && !nxt_flag2 |=> irq_out_a_n) // RULE15
		else $error("output A level held with no flag set");

	pulse_release_b_a: assert property (style_b == DAMA_PULSE && !ev1 && !ev2 |=> irq_out_b_n) // RULE14
		else $error("output B pulse without matching increment");

	irq_gate_b_a: assert property (b_gated_off_s |=> irq_out_b_n) // RULE13
		else $error("output B active with both alarm enables off");

	elapsed_store_a: assert property (hr_high_write_s |=> alm[`DAMA_IDX_A1_HR_HIGH] == $past(reg_wdata)) // RULE12
		else $error("elapsed hour byte not stored whole");

	weekday_mask_a: assert property (wday_write_s |=> alm[`DAMA_IDX_A2_HR_HIGH][7:3] == 5'h00) // RULE18
		else $error("weekday alarm byte kept unimplemented bits");
endmodule // dama_top

// File: verif/dama_time_src.sv
// Time base model that loads a new current time and flags each increment.
`timescale 1ns/1ps
module dama_time_src (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        step,
	input  wire logic [63:0] load_val,
	output logic      [63:0] cur_q,
	output logic             tick
);
	// The new time and its tick appear together, as after a real counter increment.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_q <= 64'h0;
			tick  <= 1'b0;
		end else begin
			tick <= step;
			if (step) begin
				cur_q <= load_val;
			end
		end
	end
endmodule // dama_time_src

// File: verif/dama_top_test.sv
// Self-checking bench for the dual alarm match unit.
`timescale 1ns/1ps
module dama_top_test;
	import dama_pkg::*;
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	dama_byte_t  reg_addr  = 8'h00;
	dama_byte_t  reg_wdata = 8'h00;
	dama_byte_t  reg_rdata;
	logic        clr1      = 1'b0;
	logic        clr2      = 1'b0;
	logic        mode      = 1'b0;
	logic        step      = 1'b0;
	logic [63:0] load_val  = 64'h0;
	logic [63:0] cur_q;
	logic        tick;
	logic        flag1;
	logic        flag2;
	logic        irq_a_n;
	logic        irq_b_n;
	int          fails     = 0;
	int          compares  = 0;
	int          cycles    = 0;
	dama_byte_t  regs [11] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h29, 8'h2a};
	dama_byte_t  ma [8]    = '{8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0f, 8'h10, 8'h11, 8'h2a};
	dama_byte_t  me [8]    = '{8'h7f, 8'h3f, 8'h3f, 8'h1f, 8'h07, 8'hff, 8'h00, 8'hff};
	dama_byte_t  calv [8]  = '{8'h30, 8'h15, 8'h08, 8'h21, 8'h06, 8'h45, 8'h10, 8'h03};
	dama_byte_t  elv [8]   = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h99, 8'h21, 8'h43, 8'h65};

	// Clock of 100 MHz.
	always #5 clk = ~clk;

	dama_top uut (
		.clk                   (clk),
		.rst                   (rst),
		.reg_wr                (reg_wr),
		.reg_rd                (reg_rd),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_rdata             (reg_rdata),
		.flag_clr_first        (clr1),
		.flag_clr_second       (clr2),
		.elapsed_time_mode_sel (mode),
		.time_tick             (tick),
		.cur_sec               (cur_q[63:56]),
		.cur_min               (cur_q[55:48]),
		.cur_hr_low            (cur_q[47:40]),
		.cur_hr_mid            (cur_q[39:32]),
		.cur_hr_high           (cur_q[31:24]),
		.cur_day               (cur_q[23:16]),
		.cur_month             (cur_q[15:8]),
		.cur_wday              (cur_q[7:0]),
		.first_alarm_flag      (flag1),
		.second_alarm_flag     (flag2),
		.irq_out_a_n           (irq_a_n),
		.irq_out_b_n           (irq_b_n)
	);

	dama_time_src tsrc (
		.clk      (clk),
		.rst      (rst),
		.step     (step),
		.load_val (load_val),
		.cur_q    (cur_q),
		.tick     (tick)
	);

	// Prints the counts and the verdict, then stops the run.
	task automatic results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			results();
		end
	end

	// Compares a seen value against the expected one.
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Register write of one byte.
	task automatic wr(input dama_byte_t a, input dama_byte_t d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Register read of one byte, compared with the expected value.
	task automatic rd(input dama_byte_t a, input dama_byte_t exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, exp);
	endtask

	// Checks flags and interrupt pins, packed as flag1, flag2, irq_a_n, irq_b_n.
	task automatic st(input logic [3:0] exp);
		chk("flags_irqs", {4'h0, flag1, flag2, irq_a_n, irq_b_n}, {4'h0, exp});
	endtask

	// Lets n clock edges pass and settles past the last one.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One time increment to the given time, checked in the cycle after the tick.
	task automatic tk(input logic [63:0] v, input logic [3:0] exp);
		@(posedge clk);
		step     <= 1'b1;
		load_val <= v;
		@(posedge clk);
		step <= 1'b0;
		cyc(1);
		st(exp);
	endtask

	// Host clear command for the selected flags.
	task automatic clr(input logic c1, input logic c2);
		@(posedge clk);
		clr1 <= c1;
		clr2 <= c2;
		@(posedge clk);
		clr1 <= 1'b0;
		clr2 <= 1'b0;
		cyc(1);
	endtask

	// Main sequence of tests.
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (regs[i]) rd(regs[i], 8'h00);
		$display("test reset_values done");
		foreach (ma[i]) begin
			wr(ma[i], 8'hff);
			rd(ma[i], me[i]);
		end
		@(posedge clk);
		mode <= 1'b1;
		wr(8'h0a, 8'hff);
		rd(8'h0a, 8'hff);
		@(posedge clk);
		mode <= 1'b0;
		$display("test store_masks done");
		for (int i = 0; i < 8; i++) wr(dama_byte_t'(i + 8), calv[i]);
		wr(8'h10, 8'h00);
		wr(8'h29, 8'h01);
		wr(8'h2a, 8'h82);
		tk(64'h3015080000210600, 4'b0011);
		wr(8'h10, 8'h01);
		tk(64'h3000000000000000, 4'b1001);
		cyc(20);
		st(4'b1001);
		clr(1'b1, 1'b0);
		cyc(5);
		st(4'b0011);
		wr(8'h10, 8'h1f);
		tk(64'h3015080000210700, 4'b0011);
		tk(64'h3015080000210600, 4'b1001);
		clr(1'b1, 1'b0);
		$display("test calendar_alarm1 done");
		wr(8'h10, 8'he0);
		tk(64'h0045100000000003, 4'b0110);
		cyc(1);
		st(4'b0111);
		tk(64'h0045100000000003, 4'b0110);
		cyc(1);
		st(4'b0111);
		clr(1'b0, 1'b1);
		tk(64'h0045100000000004, 4'b0011);
		$display("test calendar_alarm2 done");
		@(posedge clk);
		mode <= 1'b1;
		for (int i = 0; i < 8; i++) wr(dama_byte_t'(i + 8), elv[i]);
		wr(8'h10, 8'h1c);
		tk(64'h0000567899000000, 4'b1001);
		cyc(3);
		st(4'b1001);
		clr(1'b1, 1'b0);
		tk(64'h0000567898000000, 4'b0011);
		wr(8'h10, 8'hc0);
		tk(64'h0021436500000000, 4'b0110);
		cyc(1);
		st(4'b0111);
		$display("test elapsed_alarms done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(8'h10, 8'h00);
		tk(64'h0021436500000000, 4'b0011);
		$display("test mid_reset done");
		results();
	end
endmodule // dama_top_test
